// >>> core/fci_pkg.sv
// Constants, codes and carrier types of the file command interpreter.
package fci_pkg;

   // Host command codes.
   localparam logic [7:0] CMD_READ_BLOCK   = 8'h27;
   localparam logic [7:0] CMD_WRITE_HOST   = 8'h2C;
   localparam logic [7:0] CMD_WRITE_REQ    = 8'h2D;
   localparam logic [7:0] CMD_WRITE_OFFSET = 8'h2E;
   localparam logic [7:0] CMD_SET_NAME     = 8'h2F;
   localparam logic [7:0] CMD_GET_STATUS   = 8'h22;
   localparam logic [7:0] CMD_DISK_QUERY   = 8'h30;
   localparam logic [7:0] CMD_INIT_DISK    = 8'h31;
   localparam logic [7:0] CMD_OPEN         = 8'h32;
   localparam logic [7:0] CMD_ENUM_GO      = 8'h33;
   localparam logic [7:0] CMD_CREATE       = 8'h34;

   // Status bytes.
   localparam logic [7:0] STS_SUCCESS  = 8'h14;
   localparam logic [7:0] STS_BLK_RDY  = 8'h1D;
   localparam logic [7:0] STS_DISK_ERR = 8'h1F;
   localparam logic [7:0] STS_OPEN_DIR = 8'h41;
   localparam logic [7:0] STS_MISS     = 8'h42;

   // Lengths, characters and default values.
   localparam int         NAME_MAX      = 14;
   localparam int         BUF_DEPTH     = 256;
   localparam logic [7:0] INFO_LEN      = 8'h24;
   localparam logic [7:0] HOST_BLK_MAX  = 8'h40;
   localparam logic [7:0] OFS_BLK_MAX   = 8'h20;
   localparam logic [7:0] CH_SLASH      = 8'h2F;
   localparam logic [7:0] CH_BSLASH     = 8'h5C;
   localparam logic [7:0] CH_STAR       = 8'h2A;
   localparam logic [31:0] FLEN_DIR     = 32'h0FFFFFFF;
   localparam logic [31:0] FLEN_CREATE  = 32'h00000001;
   // Packed date 2004/1/1 and time 0:0:0.
   localparam logic [15:0] CREATE_DATE  = 16'h3021;
   localparam logic [15:0] CREATE_TIME  = 16'h0000;

   typedef logic [NAME_MAX-1:0][7:0] name_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ARGS = 2'b01,
      ST_READ = 2'b10,
      ST_WAIT = 2'b11
   } state_t;

   typedef enum logic [2:0] {
      OP_QUERY = 3'b000, OP_MOUNT = 3'b001, OP_INIT = 3'b010,
      OP_OPEN  = 3'b011, OP_ENUM  = 3'b100, OP_NEXT = 3'b101,
      OP_CREATE = 3'b110
   } med_op_t;

   typedef enum logic [1:0] {
      PATH_EMPTY = 2'b00, PATH_ROOT = 2'b01,
      PATH_ABS   = 2'b10, PATH_REL  = 2'b11
   } path_t;

   typedef enum logic [1:0] {
      RSP_OK = 2'b00, RSP_DIR = 2'b01, RSP_MISS = 2'b10, RSP_FAIL = 2'b11
   } rsp_kind_t;

   typedef struct packed {
      logic       wr;
      logic       cmd;
      logic [7:0] data;
      logic       rd;
   } host_in_t;

   typedef struct packed {
      logic        valid;
      med_op_t     op;
      path_t       path;
      logic [15:0] date;
      logic [15:0] time_of_day;
   } med_req_t;

   typedef struct packed {
      logic        valid;
      rsp_kind_t   kind;
      logic [31:0] flen;
      logic [7:0]  blen;
   } med_rsp_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] addr;
      logic [7:0] data;
   } buf_wr_t;

   typedef struct packed {
      state_t      st;
      logic [7:0]  cmd;
      logic [7:0]  cnt;
      logic [7:0]  len;
      logic [7:0]  ofs;
      logic [7:0]  idx;
      logic [7:0]  blen;
      logic [7:0]  sts;
      logic        irq_n;
      logic        busy;
      logic [7:0]  dout;
      name_t       name;
      logic [3:0]  nlen;
      logic        enum_on;
      logic        mounted;
      logic [31:0] flen;
      med_req_t    req;
   } core_t;

endpackage : fci_pkg

// >>> core/file_command_interpreter.sv
// Byte command interpreter of a file manager with its data block buffer.
//
// Contract
// - Block read returns a length byte, then exactly that many buffer bytes.
// - Block lengths are 0..255 for file transfers, 0..64 for endpoint ones.
// - Open with an empty name only initialises the file system.
// - Lone slash is root, leading slash is root entry, else current dir.
// - Disk query allowed any time; completes with status and interrupt.
// - After first good disk initialise, block read yields 36 bytes.
// - Opening a directory reports directory status, length 0FFFFFFFH.
// - Opening a file reports success and length; missing reports not found.
// - Each enumeration match raises block ready status with its record.
// - Enumeration end raises not found status.
// - Create replaces an entry of the same name; wildcards refused.
// - New file gets date 2004/1/1 0:0:0 and length 1.
// - Success status is 14H.
// - Block ready status is 1DH.
// - Directory opened status is 41H.
// - Entry not found status is 42H.
`timescale 1ns/100ps
module file_command_interpreter (
   // Clock and reset
   input  wire logic               clk,
   input  wire logic               arst_n,
   // Host command port
   input  wire fci_pkg::host_in_t  host_in,
   output logic [7:0]              host_dout,
   output logic                    irq_n,
   output logic                    busy,
   // Storage engine port
   output fci_pkg::med_req_t       med_req,
   output fci_pkg::name_t          med_name,
   output logic [31:0]             file_len,
   input  wire fci_pkg::med_rsp_t  med_rsp,
   input  wire fci_pkg::buf_wr_t   med_wr
);
   import fci_pkg::*;

   localparam core_t CORE_RST = '{st: ST_IDLE, irq_n: 1'b1, req: '0,
                                  default: '0};

   core_t      s_r;
   core_t      s_nxt;
   logic [7:0] blk_mem [BUF_DEPTH];
   buf_wr_t    bw;
   logic       wild;
   path_t      path;

   function automatic path_t path_of(input name_t nm, input logic [3:0] n);
      path_t p;
      p = PATH_REL;
      if (n == 4'h0)
         p = PATH_EMPTY;
      else if (nm[0] == CH_SLASH || nm[0] == CH_BSLASH)
         p = (n == 4'h1) ? PATH_ROOT : PATH_ABS;
      return p;
   endfunction : path_of

   assign path = path_of(s_r.name, s_r.nlen);
   assign wild = (s_r.nlen != 4'h0) && (s_r.name[s_r.nlen - 4'h1] == CH_STAR);

   always_comb begin
      s_nxt = s_r;
      s_nxt.req.valid = 1'b0;
      bw = '0;
      case (s_r.st)
         ST_IDLE: begin
            if (host_in.wr && host_in.cmd) begin
               s_nxt.cmd = host_in.data;
               s_nxt.req.path = path;
               s_nxt.req.date = CREATE_DATE;
               s_nxt.req.time_of_day = CREATE_TIME;
               case (host_in.data)
                  CMD_READ_BLOCK: begin
                     s_nxt.st = ST_READ;
                     s_nxt.dout = s_r.blen;
                     s_nxt.cnt = s_r.blen;
                     s_nxt.idx = 8'h00;
                     s_nxt.busy = 1'b1;
                  end
                  CMD_GET_STATUS: begin
                     s_nxt.dout = s_r.sts;
                     s_nxt.irq_n = 1'b1;
                  end
                  CMD_WRITE_HOST, CMD_WRITE_REQ, CMD_WRITE_OFFSET: begin
                     s_nxt.st = ST_ARGS;
                     s_nxt.busy = 1'b1;
                     s_nxt.ofs = 8'h00;
                     s_nxt.cnt = (host_in.data == CMD_WRITE_OFFSET) ?
                                 8'h00 : 8'h01;
                  end
                  CMD_SET_NAME: begin
                     s_nxt.st = ST_ARGS;
                     s_nxt.busy = 1'b1;
                     s_nxt.nlen = 4'h0;
                     s_nxt.name = '0;
                  end
                  CMD_DISK_QUERY: begin
                     s_nxt.st = ST_WAIT;
                     s_nxt.busy = 1'b1;
                     s_nxt.req.valid = 1'b1;
                     s_nxt.req.op = OP_QUERY;
                  end
                  CMD_INIT_DISK: begin
                     s_nxt.st = ST_WAIT;
                     s_nxt.busy = 1'b1;
                     s_nxt.req.valid = 1'b1;
                     s_nxt.req.op = OP_MOUNT;
                  end
                  CMD_OPEN: begin
                     s_nxt.st = ST_WAIT;
                     s_nxt.busy = 1'b1;
                     s_nxt.req.valid = 1'b1;
                     s_nxt.enum_on = 1'b0;
                     s_nxt.req.op = (path == PATH_EMPTY) ? OP_INIT :
                                    wild ? OP_ENUM : OP_OPEN;
                  end
                  CMD_ENUM_GO: begin
                     if (s_r.enum_on) begin
                        s_nxt.st = ST_WAIT;
                        s_nxt.busy = 1'b1;
                        s_nxt.req.valid = 1'b1;
                        s_nxt.req.op = OP_NEXT;
                     end else begin
                        s_nxt.sts = STS_MISS;
                        s_nxt.irq_n = 1'b0;
                     end
                  end
                  CMD_CREATE: begin
                     if (wild || path == PATH_EMPTY) begin
                        s_nxt.sts = STS_MISS;
                        s_nxt.irq_n = 1'b0;
                     end else begin
                        s_nxt.st = ST_WAIT;
                        s_nxt.busy = 1'b1;
                        s_nxt.req.valid = 1'b1;
                        s_nxt.req.op = OP_CREATE;
                     end
                  end
                  default: s_nxt.cmd = s_r.cmd;
               endcase
            end
         end
         ST_READ: begin
            if (host_in.rd) begin
               if (s_r.cnt == 8'h00) begin
                  s_nxt.st = ST_IDLE;
                  s_nxt.busy = 1'b0;
               end else begin
                  s_nxt.dout = blk_mem[s_r.idx];
                  s_nxt.idx = s_r.idx + 8'h01;
                  s_nxt.cnt = s_r.cnt - 8'h01;
               end
            end
         end
         ST_ARGS: begin
            if (host_in.wr && !host_in.cmd) begin
               if (s_r.cmd == CMD_SET_NAME) begin
                  if (host_in.data == 8'h00) begin
                     s_nxt.st = ST_IDLE;
                     s_nxt.busy = 1'b0;
                  end else if (s_r.nlen < 4'(NAME_MAX - 1)) begin
                     s_nxt.name[s_r.nlen] = host_in.data;
                     s_nxt.nlen = s_r.nlen + 4'h1;
                  end
               end else if (s_r.cnt == 8'h00) begin
                  s_nxt.ofs = host_in.data;
                  s_nxt.cnt = 8'h01;
               end else if (s_r.cnt == 8'h01) begin
                  s_nxt.len = host_in.data;
                  s_nxt.idx = 8'h00;
                  s_nxt.cnt = 8'h02;
                  if (s_r.cmd != CMD_WRITE_OFFSET)
                     s_nxt.blen = host_in.data;
                  if (host_in.data == 8'h00) begin
                     s_nxt.st = ST_IDLE;
                     s_nxt.busy = 1'b0;
                  end
               end else begin
                  bw.valid = 1'b1;
                  bw.addr = s_r.ofs + s_r.idx;
                  bw.data = host_in.data;
                  s_nxt.idx = s_r.idx + 8'h01;
                  if (s_r.idx + 8'h01 == s_r.len) begin
                     s_nxt.st = ST_IDLE;
                     s_nxt.busy = 1'b0;
                  end
               end
            end
         end
         ST_WAIT: begin
            bw = med_wr;
            if (med_rsp.valid) begin
               s_nxt.st = ST_IDLE;
               s_nxt.busy = 1'b0;
               s_nxt.irq_n = 1'b0;
               s_nxt.sts = STS_SUCCESS;
               case (s_r.req.op)
                  OP_MOUNT: begin
                     if (med_rsp.kind == RSP_OK && !s_r.mounted) begin
                        s_nxt.mounted = 1'b1;
                        s_nxt.blen = INFO_LEN;
                     end
                  end
                  OP_OPEN: begin
                     if (med_rsp.kind == RSP_DIR) begin
                        s_nxt.sts = STS_OPEN_DIR;
                        s_nxt.flen = FLEN_DIR;
                     end else if (med_rsp.kind == RSP_MISS) begin
                        s_nxt.sts = STS_MISS;
                     end else begin
                        s_nxt.flen = med_rsp.flen;
                     end
                  end
                  OP_ENUM, OP_NEXT: begin
                     if (med_rsp.kind == RSP_OK) begin
                        s_nxt.sts = STS_BLK_RDY;
                        s_nxt.blen = med_rsp.blen;
                        s_nxt.enum_on = 1'b1;
                     end else begin
                        s_nxt.sts = STS_MISS;
                        s_nxt.enum_on = 1'b0;
                     end
                  end
                  OP_CREATE: s_nxt.flen = FLEN_CREATE;
                  default: s_nxt.sts = STS_SUCCESS;
               endcase
               if (med_rsp.kind == RSP_FAIL) begin
                  s_nxt.sts = STS_DISK_ERR;
                  s_nxt.enum_on = 1'b0;
               end
            end
         end
         default: s_nxt = CORE_RST;
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n)
         s_r <= CORE_RST;
      else
         s_r <= s_nxt;
   end

   // The buffer has no reset; its contents are defined by the writers only.
   always_ff @(posedge clk) begin
      if (bw.valid)
         blk_mem[bw.addr] <= bw.data;
   end

   assign host_dout = s_r.dout;
   assign irq_n     = s_r.irq_n;
   assign busy      = s_r.busy;
   assign med_req   = s_r.req;
   assign med_name  = s_r.name;
   assign file_len  = s_r.flen;

   wire cmd_in = s_r.st == ST_IDLE && host_in.wr && host_in.cmd;
   wire done = s_r.st == ST_WAIT && med_rsp.valid && med_rsp.kind != RSP_FAIL;

   chk_read_len: assert property (@(posedge clk) disable iff (!arst_n)
      cmd_in && host_in.data == CMD_READ_BLOCK |=>
         host_dout == $past(s_r.blen) && s_r.st == ST_READ)
      else $error("read block does not start with length");
   chk_read_end: assert property (@(posedge clk) disable iff (!arst_n)
      s_r.st == ST_READ && host_in.rd && s_r.cnt == 8'h00 |=> !busy)
      else $error("read block overruns its length");
   chk_mount_id: assert property (@(posedge clk) disable iff (!arst_n)
      done && s_r.req.op == OP_MOUNT && !s_r.mounted |=>
         s_r.blen == INFO_LEN && s_r.sts == STS_SUCCESS)
      else $error("first mount block length wrong");
   chk_open_dir: assert property (@(posedge clk) disable iff (!arst_n)
      done && s_r.req.op == OP_OPEN && med_rsp.kind == RSP_DIR |=>
         s_r.sts == STS_OPEN_DIR && file_len == FLEN_DIR && !irq_n)
      else $error("directory open status or length wrong");
   chk_no_entry: assert property (@(posedge clk) disable iff (!arst_n)
      done && s_r.req.op == OP_OPEN && med_rsp.kind == RSP_MISS |=>
         s_r.sts == STS_MISS)
      else $error("missing entry not reported");
   chk_enum_hit: assert property (@(posedge clk) disable iff (!arst_n)
      done && s_r.req.op inside {OP_ENUM, OP_NEXT} && med_rsp.kind == RSP_OK
         |=> s_r.sts == STS_BLK_RDY && s_r.enum_on)
      else $error("enumeration match not reported");
   chk_enum_end: assert property (@(posedge clk) disable iff (!arst_n)
      done && s_r.req.op == OP_NEXT && med_rsp.kind == RSP_MISS |=>
         s_r.sts == STS_MISS && !s_r.enum_on)
      else $error("enumeration end not reported");
   chk_no_wild: assert property (@(posedge clk) disable iff (!arst_n)
      cmd_in && host_in.data == CMD_CREATE && wild |=>
         !med_req.valid && s_r.st == ST_IDLE)
      else $error("wildcard create accepted");
   chk_init_only: assert property (@(posedge clk) disable iff (!arst_n)
      cmd_in && host_in.data == CMD_OPEN && s_r.nlen == 4'h0 |=>
         med_req.valid && med_req.op == OP_INIT)
      else $error("empty name open not init only");
   chk_irq_hold: assert property (@(posedge clk) disable iff (!arst_n)
      !irq_n && !(cmd_in && host_in.data == CMD_GET_STATUS) |=>
         !irq_n && $stable(s_r.sts))
      else $error("interrupt or status lost before read");

   cov_enum: cover property (@(posedge clk) disable iff (!arst_n)
      done && s_r.req.op == OP_NEXT);
   cov_dir: cover property (@(posedge clk) disable iff (!arst_n)
      done && med_rsp.kind == RSP_DIR);
   cov_read: cover property (@(posedge clk) disable iff (!arst_n)
      s_r.st == ST_READ && s_r.cnt == 8'h00 && host_in.rd);

endmodule : file_command_interpreter

// >>> dv/storage_model.sv
// Behavioural storage engine that answers the interpreter's requests.
`timescale 1ns/100ps
module storage_model (
   // Clock and reset
   input  wire logic               clk,
   input  wire logic               arst_n,
   // Interpreter side
   input  wire fci_pkg::med_req_t  med_req,
   output fci_pkg::med_rsp_t       med_rsp,
   output fci_pkg::buf_wr_t        med_wr,
   // Bench controls
   input  wire fci_pkg::rsp_kind_t kind,
   input  wire logic [31:0]        flen,
   input  wire logic [7:0]         blen,
   input  wire logic [7:0]         base,
   input  wire logic [7:0]         lat,
   output fci_pkg::med_req_t       last_req,
   output logic [7:0]              n_req
);
   import fci_pkg::*;

   initial begin
      med_rsp  = '0;
      med_wr   = '0;
      last_req = '0;
      n_req    = 8'h00;
      forever begin
         @(posedge clk);
         if (arst_n && med_req.valid) begin
            last_req <= med_req;
            n_req    <= n_req + 8'h01;
            repeat (lat) @(posedge clk);
            for (int i = 0; i < blen; i++) begin
               med_wr <= '{1'h1, i[7:0], base + i[7:0]};
               @(posedge clk);
            end
            // Idle bus shows a changing pattern, never the last value.
            med_wr  <= '{1'h0, ~med_wr.addr, ~med_wr.data};
            med_rsp <= '{1'h1, kind, flen, blen};
            @(posedge clk);
            med_rsp <= '{1'h0, kind, ~flen, ~blen};
         end
      end
   end
endmodule : storage_model

// >>> dv/testbench.sv
// Self-checking bench of the file command interpreter.
`timescale 1ns/100ps
module testbench;
   import fci_pkg::*;

   logic        clk;
   logic        arst_n;
   host_in_t    host_in;
   logic [7:0]  host_dout;
   logic        irq_n;
   logic        busy;
   med_req_t    med_req;
   name_t       med_name;
   logic [31:0] file_len;
   med_rsp_t    med_rsp;
   buf_wr_t     med_wr;
   rsp_kind_t   kind;
   logic [31:0] flen;
   logic [7:0]  blen;
   logic [7:0]  base;
   logic [7:0]  lat;
   med_req_t    last_req;
   logic [7:0]  n_req;
   logic        show;
   logic        pend;
   logic [7:0]  mem [256];
   logic [7:0]  exp_q [$];
   int          blk_len;
   int          n_fail;
   int          n_checks;
   int          cycles;
   integer      seed;

   file_command_interpreter i_file_command_interpreter (
      .clk(clk), .arst_n(arst_n), .host_in(host_in), .host_dout(host_dout),
      .irq_n(irq_n), .busy(busy), .med_req(med_req), .med_name(med_name),
      .file_len(file_len), .med_rsp(med_rsp), .med_wr(med_wr));

   storage_model i_storage_model (
      .clk(clk), .arst_n(arst_n), .med_req(med_req), .med_rsp(med_rsp),
      .med_wr(med_wr), .kind(kind), .flen(flen), .blen(blen), .base(base),
      .lat(lat), .last_req(last_req), .n_req(n_req));

   always #5 clk = ~clk;

   task automatic close_out;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : close_out

   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // The hang limit covers the whole sequence with wide margin.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 30000) begin
         n_fail++;
         close_out();
      end
   end

   // A noted byte is compared one cycle after the edge that asked for it.
   always @(posedge clk) begin
      if (pend) begin
         if (exp_q.size() == 0)
            check("spare host byte", 32'h1, 32'h0);
         else
            check("host byte", host_dout, exp_q.pop_front());
      end
      pend <= show;
   end

   task automatic put(input logic c, input logic [7:0] d, input logic r,
                      input logic s);
      @(negedge clk);
      host_in = '{wr: ~r, cmd: c, data: d, rd: r};
      show    = s;
      @(negedge clk);
      host_in = '0;
      show    = 1'h0;
   endtask : put

   task automatic send_cmd(input logic [7:0] c, input logic s);
      for (int i = 0; i < 500 && busy !== 1'h0; i++) @(negedge clk);
      put(1'h1, c, 1'h0, s);
   endtask : send_cmd

   task automatic set_name(input string s);
      send_cmd(CMD_SET_NAME, 1'h0);
      for (int i = 0; i < s.len(); i++) put(1'h0, s[i], 1'h0, 1'h0);
      put(1'h0, 8'h00, 1'h0, 1'h0);
   endtask : set_name

   task automatic write_blk(input logic [7:0] c, input logic [7:0] n);
      send_cmd(c, 1'h0);
      put(1'h0, n, 1'h0, 1'h0);
      for (int i = 0; i < n; i++) begin
         mem[i] = 8'($random(seed));
         put(1'h0, mem[i], 1'h0, 1'h0);
      end
      blk_len = n;
   endtask : write_blk

   // offset plus length stays below 32
   task automatic wr_ofs(input logic [7:0] o);
      send_cmd(CMD_WRITE_OFFSET, 1'h0);
      put(1'h0, o, 1'h0, 1'h0);
      put(1'h0, OFS_BLK_MAX - 8'h01 - o, 1'h0, 1'h0);
      for (int i = o; i < 31; i++) begin
         mem[i] = 8'($random(seed));
         put(1'h0, mem[i], 1'h0, 1'h0);
      end
   endtask : wr_ofs

   task automatic read_blk;
      exp_q.push_back(8'(blk_len));
      send_cmd(CMD_READ_BLOCK, 1'h1);
      for (int i = 0; i < blk_len; i++) begin
         exp_q.push_back(mem[i]);
         put(1'h0, 8'h00, 1'h1, 1'h1);
      end
      put(1'h0, 8'h00, 1'h1, 1'h0);
   endtask : read_blk

   task automatic fill(input logic [7:0] n);
      for (int i = 0; i < n; i++) mem[i] = base + i[7:0];
      blk_len = n;
   endtask : fill

   task automatic do_op(input logic [7:0] c, input rsp_kind_t k,
                        input logic [7:0] bl, input logic req,
                        input med_op_t op, input logic [7:0] sts);
      logic [7:0] n0;
      n0   = n_req;
      kind = k;
      blen = bl;
      send_cmd(c, 1'h0);
      for (int i = 0; i < 500 && irq_n !== 1'h0; i++) @(negedge clk);
      repeat (3) @(negedge clk);
      check("irq held", irq_n, 1'h0);
      check("requests", n_req, n0 + {7'h00, req});
      if (req)
         check("request op", last_req.op, op);
      exp_q.push_back(sts);
      send_cmd(CMD_GET_STATUS, 1'h1);
      check("irq released", irq_n, 1'h1);
   endtask : do_op

   initial begin
      seed    = 81131;
      clk     = 1'h0;
      arst_n  = 1'h0;
      host_in = '0;
      show    = 1'h0;
      kind    = RSP_OK;
      flen    = 32'h0;
      blen    = 8'h00;
      base    = 8'h00;
      lat     = 8'h02;
      repeat (16) @(negedge clk);
      arst_n = 1'h1;
      check("reset irq", irq_n, 1'h1);
      check("reset busy", busy, 1'h0);
      check("reset length", file_len, 32'h0);
      // endpoint block at its largest size
      write_blk(CMD_WRITE_HOST, HOST_BLK_MAX);
      read_blk();
      wr_ofs(8'($random(seed)) & 8'h0F);
      read_blk();
      write_blk(CMD_WRITE_REQ, 8'h00);
      read_blk();
      for (int i = 0; i < 2; i++) begin
         write_blk(CMD_WRITE_REQ, 8'($random(seed)));
         read_blk();
      end
      do_op(CMD_DISK_QUERY, RSP_OK, 8'h00, 1'h1, OP_QUERY, STS_SUCCESS);
      do_op(CMD_INIT_DISK, RSP_FAIL, 8'h00, 1'h1, OP_MOUNT, STS_DISK_ERR);
      base = 8'h60;
      lat  = 8'h07;
      do_op(CMD_INIT_DISK, RSP_OK, 8'h24, 1'h1, OP_MOUNT, STS_SUCCESS);
      fill(8'h24);
      read_blk();
      flen = 32'($random(seed));
      set_name("/");
      do_op(CMD_OPEN, RSP_DIR, 8'h00, 1'h1, OP_OPEN, STS_OPEN_DIR);
      check("root path", last_req.path, PATH_ROOT);
      check("dir length", file_len, 32'h0FFFFFFF);
      set_name("");
      do_op(CMD_OPEN, RSP_OK, 8'h00, 1'h1, OP_INIT, STS_SUCCESS);
      set_name("/A.TXT");
      check("name head", {med_name[0], med_name[1]}, 16'h2F41);
      do_op(CMD_OPEN, RSP_OK, 8'h00, 1'h1, OP_OPEN, STS_SUCCESS);
      check("abs path", last_req.path, PATH_ABS);
      check("file length", file_len, flen);
      set_name("/DOCS");
      do_op(CMD_OPEN, RSP_DIR, 8'h00, 1'h1, OP_OPEN, STS_OPEN_DIR);
      check("sub length", file_len, 32'h0FFFFFFF);
      set_name("SUB");
      do_op(CMD_OPEN, RSP_MISS, 8'h00, 1'h1, OP_OPEN, STS_MISS);
      check("rel path", last_req.path, PATH_REL);
      set_name("/*");
      base = 8'h20;
      do_op(CMD_OPEN, RSP_OK, 8'h20, 1'h1, OP_ENUM, STS_BLK_RDY);
      fill(8'h20);
      read_blk();
      base = 8'h90;
      do_op(CMD_ENUM_GO, RSP_OK, 8'h20, 1'h1, OP_NEXT, STS_BLK_RDY);
      fill(8'h20);
      read_blk();
      do_op(CMD_ENUM_GO, RSP_MISS, 8'h00, 1'h1, OP_NEXT, STS_MISS);
      do_op(CMD_ENUM_GO, RSP_OK, 8'h00, 1'h0, OP_NEXT, STS_MISS);
      set_name("/NEW.TXT");
      do_op(CMD_CREATE, RSP_OK, 8'h00, 1'h1, OP_CREATE, STS_SUCCESS);
      // FAT packed date of 2004/1/1 is 3021h, midnight is zero.
      check("create date", last_req.date, 16'h3021);
      check("create time", last_req.time_of_day, 16'h0000);
      check("create length", file_len, 32'h1);
      set_name("/X*");
      do_op(CMD_CREATE, RSP_OK, 8'h00, 1'h0, OP_CREATE, STS_MISS);
      repeat (4) @(negedge clk);
      check("notes left", exp_q.size(), 32'h0);
      close_out();
   end
endmodule : testbench
